//--- vdm_consts.svh
/*
  Constants of the bridge transfer-engine front end: register offsets,
  field positions, reset values and sizes.
  Assumes it is included by bare name from every design file that needs it.
*/
// Operation
// - Direct and chained operating modes supported.
// - Chained mode loads packets, follows links.
// - Transfer registers start at offset 0x200.
// - Writes to transfer registers ignored while active.
// - Direction bit picks source and destination.
// - PCI side is byte address, memory only.
// - VME side: space and sub-space fields.
// - Low three address bits differ: refuse, flag.
// - Misalignment raises enabled interrupt, stops chaining.
// - Direct mode leaves address registers unchanged.
// - Chained mode writes back addresses on exit.
// - Address reads while active give PCI remainder.
// - Chained success: addresses follow block, count zero.
// - One combined status and control register.
// - Count frozen while running, then zero/remaining.
// - Zero count starts only a chained fetch.
`ifndef VDM_CONSTS_SVH
`define VDM_CONSTS_SVH

// ****************************************************************
// Register offsets inside the device register map.
// ****************************************************************
`define VDM_OFS_CTRL 12'h200
`define VDM_OFS_COUNT 12'h204
`define VDM_OFS_PCI 12'h208
`define VDM_OFS_VME 12'h210
`define VDM_OFS_PKT 12'h218
`define VDM_OFS_GCS 12'h220

// ****************************************************************
// Field positions.
// ****************************************************************
`define VDM_CTRL_DIR 31
`define VDM_CTRL_SPACE_HI 18
`define VDM_CTRL_SPACE_LO 16
`define VDM_CTRL_PGM 14
`define VDM_CTRL_SUPER 12
`define VDM_GCS_GO 31
`define VDM_GCS_STOP 30
`define VDM_GCS_CHAIN 27
`define VDM_GCS_ACT 15
`define VDM_GCS_DONE 11
`define VDM_GCS_ERR 10
`define VDM_GCS_STOPPED 9
`define VDM_GCS_PERR 8
`define VDM_GCS_PERR_EN 0
`define VDM_PKT_LAST 0

// ****************************************************************
// Reset values, sizes and counts.
// ****************************************************************
`define VDM_RST_WORD 32'h00000000
`define VDM_RST_COUNT 24'h000000
`define VDM_BEAT_BYTES 24'h000004
`define VDM_PKT_ALIGN_MASK 32'hffffffe0
`define VDM_PKT_LAST_INDEX 3'h7
`define VDM_PKT_IDX_CTRL 3'h0
`define VDM_PKT_IDX_COUNT 3'h1
`define VDM_PKT_IDX_PCI 3'h2
`define VDM_PKT_IDX_VME 3'h4
`define VDM_PKT_IDX_LINK 3'h6

`endif

//--- vdm_pkg.sv
/*
  Types shared by the transfer-engine front end.
  Assumes nothing of its surroundings.
*/
package vdm_pkg;

  // Engine sequencing states.
  typedef enum logic [1:0] {VDM_IDLE, VDM_FETCH, VDM_CHECK, VDM_RUN} vdm_state_t;

endpackage

//--- vdm_byte_counter.sv
/*
  Remaining-byte counter of one side of a transfer.
  Assumes one beat moves at most four bytes and load and beat never coincide.
*/
`timescale 1ns/1ps
`include "vdm_consts.svh"

module vdm_byte_counter (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [23:0] loadValue,
  input wire logic beat,
  output logic [23:0] count,
  output logic [23:0] countNext
);

  // Bytes that one beat retires: four, or what is left if less.
  logic [23:0] beatBytes;

  assign beatBytes = (count >= `VDM_BEAT_BYTES) ? `VDM_BEAT_BYTES : count;
  assign countNext = load ? loadValue : (beat ? count - beatBytes : count);

  // The count register itself.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      count <= `VDM_RST_COUNT;
    else
      count <= countNext;
  end

endmodule

//--- vdm_skid_buffer.sv
/*
  Two-entry data buffer with valid and ready on both sides.
  Assumes the writer only pushes while inReady is high.
*/
`timescale 1ns/1ps
`include "vdm_consts.svh"

module vdm_skid_buffer (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic inValid,
  input wire logic [31:0] inData,
  output logic inReady,
  output logic spaceNext,
  output logic outValid,
  output logic [31:0] outData,
  input wire logic outReady
);

  // Occupancy, second entry and handshake terms.
  logic [1:0] cnt;
  logic [1:0] cntNext;
  logic [31:0] entry1;
  logic push;
  logic pop;

  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign cntNext = flush ? 2'h0 : cnt + {1'b0, push} - {1'b0, pop};
  assign spaceNext = (cntNext != 2'h2);

  // Head entry sits in outData so the reader sees a register.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt <= 2'h0;
      inReady <= 1'b0;
      outValid <= 1'b0;
      outData <= `VDM_RST_WORD;
      entry1 <= `VDM_RST_WORD;
    end
    else
    begin
      cnt <= cntNext;
      inReady <= spaceNext;
      outValid <= (cntNext != 2'h0);
      // The head moves up from the second entry or takes new data.
      if (pop && cnt == 2'h2)
        outData <= entry1;
      else if (push && (cnt == 2'h0 || (cnt == 2'h1 && pop)))
        outData <= inData;
      // New data lands in the second entry, behind a head that stays or that moves up from it.
      if (push && ((cnt == 2'h1 && !pop) || (cnt == 2'h2 && pop)))
        entry1 <= inData;
    end
  end

endmodule

//--- vdm_dma_front.sv
/*
  Register front end and sequencer of the bridge transfer engine: transfer
  registers, direct and chained operation, alignment check, data path with
  a two-entry buffer, and write-back of addresses and byte count.
  Assumes all inputs come from logic on ref_clk and the packet reader
  returns the eight words of a packet in index order.
*/
`timescale 1ns/1ps
`include "vdm_consts.svh"

module vdm_dma_front (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [11:0] regAddr,
  input wire logic [31:0] regWrData,
  output logic [31:0] regRdData,
  output logic regRdValid,
  output logic pktReqValid,
  output logic [31:0] pktReqAddr,
  input wire logic pktRspValid,
  input wire logic [2:0] pktRspIndex,
  input wire logic [31:0] pktRspData,
  input wire logic xferError,
  input wire logic srcValid,
  input wire logic [31:0] srcData,
  output logic srcReady,
  output logic dstValid,
  output logic [31:0] dstData,
  input wire logic dstReady,
  output logic engineActive,
  output logic pciToVmeDirection,
  output logic [2:0] vmeAddressSpaceSelect,
  output logic programDataSelect,
  output logic supervisorSelect,
  output logic [31:0] pciAddrOut,
  output logic [31:0] vmeAddrOut,
  output logic irq
);

  // ****************************************************************
  // Registers and state.
  // ****************************************************************
  vdm_pkg::vdm_state_t stateReg; // Sequencer state.
  vdm_pkg::vdm_state_t stateNext; // Its next value.
  logic [31:0] transferControlReg; // Direction, space and sub-space.
  logic [23:0] byteCountReg; // Byte count, frozen while running.
  logic [31:0] pciAddressReg; // PCI memory byte address.
  logic [31:0] vmeAddressReg; // VME byte address.
  logic [31:0] packetPointerReg; // Current command packet pointer.
  logic chainEnableReg; // Chained mode selected.
  logic perrIrqEnableReg; // Misalignment interrupt enable.
  logic lastPacketReg; // Current packet ends the list.
  logic [3:0] statusReg; // Done, error, stopped, protocol error.
  logic [3:0] statusNext; // Its next value.
  logic srcReadyReg; // Registered source ready.

  // ****************************************************************
  // Decoding of register accesses.
  // ****************************************************************
  wire engineBusy = (stateReg != vdm_pkg::VDM_IDLE);
  wire selCtrl = (regAddr == `VDM_OFS_CTRL);
  wire selCount = (regAddr == `VDM_OFS_COUNT);
  wire selPci = (regAddr == `VDM_OFS_PCI);
  wire selVme = (regAddr == `VDM_OFS_VME);
  wire selPkt = (regAddr == `VDM_OFS_PKT);
  wire selGcs = (regAddr == `VDM_OFS_GCS);
  // Writes to the transfer registers are dropped while busy.
  wire xferWrite = regWrite && !engineBusy;
  wire goReq = regWrite && selGcs && regWrData[`VDM_GCS_GO];
  // A zero count only starts a fetch, judged by the chaining bit written with the start.
  wire startCheck = goReq && (byteCountReg != `VDM_RST_COUNT);
  wire startFetch = goReq && (byteCountReg == `VDM_RST_COUNT) && regWrData[`VDM_GCS_CHAIN];
  wire stopReq = regWrite && selGcs && regWrData[`VDM_GCS_STOP];
  wire [3:0] statusClr = (regWrite && selGcs) ? regWrData[11:8] : 4'h0;

  // ****************************************************************
  // Data path terms.
  // ****************************************************************
  logic [23:0] srcCount; // Bytes left to take on the source side.
  logic [23:0] srcCountNext;
  logic [23:0] dstCount; // Bytes left to hand to the destination.
  logic bufSpaceNext; // Buffer can take a beat next cycle; srcReadyReg follows it.
  wire srcPush = srcValid && srcReadyReg;
  wire dstPop = dstValid && dstReady;
  wire inCheck = (stateReg == vdm_pkg::VDM_CHECK);
  wire inRun = (stateReg == vdm_pkg::VDM_RUN);
  wire inFetch = (stateReg == vdm_pkg::VDM_FETCH);
  // The two addresses must agree in their low three bits.
  wire misaligned = (pciAddressReg[2:0] != vmeAddressReg[2:0]);
  wire checkFail = inCheck && misaligned;
  wire checkPass = inCheck && !misaligned;
  wire runError = inRun && xferError;
  wire runStop = inRun && stopReq && !xferError;
  wire runDone = inRun && !xferError && !stopReq && (dstCount == `VDM_RST_COUNT);
  wire runExit = inRun && (xferError || stopReq || dstCount == `VDM_RST_COUNT);
  wire [23:0] movedBytes = byteCountReg - srcCount;
  // The PCI side is the source when data flows toward VME.
  wire [23:0] pciRemaining = transferControlReg[`VDM_CTRL_DIR] ? srcCount : dstCount;
  wire pktWord = inFetch && pktRspValid;

  // ****************************************************************
  // Read multiplexer.
  // ****************************************************************
  wire [31:0] gcsView = {4'h0, chainEnableReg, 11'h000, engineBusy, 3'h0,
    statusReg, 7'h00, perrIrqEnableReg};
  // Address registers read as the PCI-side remainder while busy.
  wire [31:0] pciView = engineBusy ? {8'h00, pciRemaining} : pciAddressReg;
  wire [31:0] vmeView = engineBusy ? {8'h00, pciRemaining} : vmeAddressReg;
  wire [31:0] readMux = selCtrl ? transferControlReg :
    selCount ? {8'h00, byteCountReg} :
    selPci ? pciView :
    selVme ? vmeView :
    selPkt ? packetPointerReg :
    selGcs ? gcsView : `VDM_RST_WORD;

  // ****************************************************************
  // Sequencer.
  // ****************************************************************
  // Next state: start, packet fetch, alignment check and transfer.
  always_comb
  begin
    stateNext = stateReg;
    case (stateReg)
      vdm_pkg::VDM_IDLE:
      begin
        if (startCheck)
          stateNext = vdm_pkg::VDM_CHECK;
        else if (startFetch)
          stateNext = vdm_pkg::VDM_FETCH;
      end
      vdm_pkg::VDM_FETCH:
      begin
        // Abort the fetch on stop or error, else wait for the last word.
        if (stopReq || xferError)
          stateNext = vdm_pkg::VDM_IDLE;
        else if (pktRspValid && pktRspIndex == `VDM_PKT_LAST_INDEX)
          stateNext = vdm_pkg::VDM_CHECK;
      end
      vdm_pkg::VDM_CHECK:
      begin
        // A misaligned pair never reaches the buses and ends the list.
        stateNext = misaligned ? vdm_pkg::VDM_IDLE : vdm_pkg::VDM_RUN;
      end
      vdm_pkg::VDM_RUN:
      begin
        // A completed packet moves on along the list if there is more.
        if (runDone && chainEnableReg && !lastPacketReg)
          stateNext = vdm_pkg::VDM_FETCH;
        else if (runExit)
          stateNext = vdm_pkg::VDM_IDLE;
      end
      default:
        stateNext = vdm_pkg::VDM_IDLE;
    endcase
  end

  // ****************************************************************
  // Transfer registers.
  // ****************************************************************
  // Control register: written by software when idle or by a packet.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      transferControlReg <= `VDM_RST_WORD;
    else if (xferWrite && selCtrl)
      transferControlReg <= regWrData;
    else if (pktWord && pktRspIndex == `VDM_PKT_IDX_CTRL)
      transferControlReg <= pktRspData;
  end

  // Byte count: frozen while running, written back on the way out.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      byteCountReg <= `VDM_RST_COUNT;
    else if (xferWrite && selCount)
      byteCountReg <= regWrData[23:0];
    else if (pktWord && pktRspIndex == `VDM_PKT_IDX_COUNT)
      byteCountReg <= pktRspData[23:0];
    else if (runDone)
      byteCountReg <= `VDM_RST_COUNT;
    else if (runError || runStop)
      byteCountReg <= srcCount;
  end

  // Address registers: direct mode never touches them.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pciAddressReg <= `VDM_RST_WORD;
      vmeAddressReg <= `VDM_RST_WORD;
    end
    else if (xferWrite && selPci)
      pciAddressReg <= regWrData;
    else if (xferWrite && selVme)
      vmeAddressReg <= regWrData;
    else if (pktWord && pktRspIndex == `VDM_PKT_IDX_PCI)
      pciAddressReg <= pktRspData;
    else if (pktWord && pktRspIndex == `VDM_PKT_IDX_VME)
      vmeAddressReg <= pktRspData;
    else if (chainEnableReg && runExit)
    begin
      // On success the moved bytes are the whole count, so both land past the block.
      pciAddressReg <= pciAddressReg + {8'h00, movedBytes};
      vmeAddressReg <= vmeAddressReg + {8'h00, movedBytes};
    end
  end

  // Packet pointer, end-of-list mark, chaining and interrupt enable.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      packetPointerReg <= `VDM_RST_WORD;
      lastPacketReg <= 1'b0;
      chainEnableReg <= 1'b0;
      perrIrqEnableReg <= 1'b0;
    end
    else
    begin
      if (xferWrite && selPkt)
        packetPointerReg <= regWrData & `VDM_PKT_ALIGN_MASK;
      else if (pktWord && pktRspIndex == `VDM_PKT_IDX_LINK)
        packetPointerReg <= pktRspData & `VDM_PKT_ALIGN_MASK;
      if (pktWord && pktRspIndex == `VDM_PKT_IDX_LINK)
        lastPacketReg <= pktRspData[`VDM_PKT_LAST];
      if (xferWrite && selGcs)
      begin
        chainEnableReg <= regWrData[`VDM_GCS_CHAIN];
        perrIrqEnableReg <= regWrData[`VDM_GCS_PERR_EN];
      end
    end
  end

  // ****************************************************************
  // Status flags: set by the engine, cleared by writing a one.
  // ****************************************************************
  // A set in the same cycle as a clear wins.
  assign statusNext = (statusReg & ~statusClr) |
    {runDone && (!chainEnableReg || lastPacketReg), runError, runStop, checkFail};

  // State, status, interrupt, activity, packet request and source ready registers.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      stateReg <= vdm_pkg::VDM_IDLE;
      srcReadyReg <= 1'b0;
      statusReg <= 4'h0;
      irq <= 1'b0;
      engineActive <= 1'b0;
      pktReqValid <= 1'b0;
      pktReqAddr <= `VDM_RST_WORD;
    end
    else
    begin
      stateReg <= stateNext;
      // Source ready only while running, bytes remain and the buffer has room.
      srcReadyReg <= (stateNext == vdm_pkg::VDM_RUN) && !runExit &&
        (srcCountNext != `VDM_RST_COUNT) && bufSpaceNext;
      statusReg <= statusNext;
      irq <= statusNext[0] && perrIrqEnableReg;
      engineActive <= (stateNext != vdm_pkg::VDM_IDLE);
      pktReqValid <= (stateNext == vdm_pkg::VDM_FETCH) && !inFetch;
      pktReqAddr <= (pktWord && pktRspIndex == `VDM_PKT_IDX_LINK) ?
        (pktRspData & `VDM_PKT_ALIGN_MASK) : packetPointerReg;
    end
  end

  // ****************************************************************
  // Data path.
  // ****************************************************************
  // Source-side remaining count.
  vdm_byte_counter srcCounter (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(checkPass),
    .loadValue(byteCountReg),
    .beat(srcPush),
    .count(srcCount),
    .countNext(srcCountNext)
  );

  // Destination-side remaining count.
  vdm_byte_counter dstCounter (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(checkPass),
    .loadValue(byteCountReg),
    .beat(dstPop),
    .count(dstCount),
    .countNext()
  );

  // Buffer between source and destination; leftovers flush on exit.
  vdm_skid_buffer dataBuffer (
    .ref_clk(ref_clk),
    .rst(rst),
    .flush(runExit),
    .inValid(srcPush),
    .inData(srcData),
    .inReady(),
    .spaceNext(bufSpaceNext),
    .outValid(dstValid),
    .outData(dstData),
    .outReady(dstReady && inRun)
  );

  // Read answer registers.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      regRdData <= `VDM_RST_WORD;
      regRdValid <= 1'b0;
    end
    else
    begin
      regRdValid <= regRead;
      if (regRead)
        regRdData <= readMux;
    end
  end

  // ****************************************************************
  // Outputs taken straight from registers.
  // ****************************************************************
  assign srcReady = srcReadyReg;
  assign pciToVmeDirection = transferControlReg[`VDM_CTRL_DIR];
  assign vmeAddressSpaceSelect = transferControlReg[`VDM_CTRL_SPACE_HI:`VDM_CTRL_SPACE_LO];
  assign programDataSelect = transferControlReg[`VDM_CTRL_PGM];
  assign supervisorSelect = transferControlReg[`VDM_CTRL_SUPER];
  assign pciAddrOut = pciAddressReg;
  assign vmeAddrOut = vmeAddressReg;

endmodule

//--- vdm_dma_front_props.sv
/*
  Port checker of the transfer-engine front end.
  Assumes it is bound onto vdm_dma_front and sees only its ports.
*/
`timescale 1ns/1ps

module vdm_dma_front_props (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [11:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regRdValid,
  input wire logic pktReqValid,
  input wire logic [31:0] pktReqAddr,
  input wire logic pktRspValid,
  input wire logic srcReady,
  input wire logic dstValid,
  input wire logic [31:0] dstData,
  input wire logic dstReady,
  input wire logic engineActive,
  input wire logic pciToVmeDirection,
  input wire logic [31:0] pciAddrOut,
  input wire logic [31:0] vmeAddrOut,
  input wire logic irq
);
  // ****************************************************************
  // Helper logic and assertions.
  // ****************************************************************
  logic [23:0] cnt_reg; // Last byte count written while idle.
  logic known_reg; // Falls once a run may have rewritten the count.
  wire goWr = regWrite && regAddr == 12'h220 && regWrData[31] && !engineActive && known_reg;
  wire cntWr = regWrite && regAddr == 12'h204 && !engineActive;
  wire skewed = pciAddrOut[2:0] != vmeAddrOut[2:0];

  // The count copy lets a start be judged without seeing the register.
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      {known_reg, cnt_reg} <= 25'h0000000;
    else if (cntWr)
      {known_reg, cnt_reg} <= {1'b1, regWrData[23:0]};
    else if (engineActive)
      known_reg <= 1'b0;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_read_answer: assert property (regRead |=> regRdValid)
    else $error("read not answered");
  chk_read_pulse: assert property (!regRead |=> !regRdValid)
    else $error("stray read answer");
  chk_fetch_act: assert property (pktReqValid |-> engineActive)
    else $error("fetch while idle");
  chk_pkt_align: assert property (pktReqValid |-> pktReqAddr[4:0] == 5'h00)
    else $error("packet address not aligned");
  chk_src_gated: assert property (srcReady |-> engineActive)
    else $error("source taken while idle");
  chk_irq_cause: assert property ($rose(irq) |-> $past(engineActive))
    else $error("irq without start");
  chk_zero_idle: assert property (goWr && cnt_reg == 24'h0 && !regWrData[27] |=> !engineActive [*2])
    else $error("zero count started");
  chk_start_act: assert property (goWr && cnt_reg != 24'h0 |=> engineActive)
    else $error("start not active");
  chk_skew_stop: assert property (goWr && cnt_reg != 24'h0 && skewed |=> ##1 !engineActive)
    else $error("misaligned start ran");
  chk_dir_locked: assert property (engineActive && !pktRspValid && regWrite && regAddr == 12'h200 |=> $stable(pciToVmeDirection))
    else $error("control changed while active");
  chk_dst_hold: assert property (dstValid && !dstReady |=> dstValid && $stable(dstData))
    else $error("destination word dropped");

  cov_misalign: cover property (goWr && skewed ##2 irq);
  cov_fetch: cover property (pktReqValid);
  cov_stall: cover property (dstValid && !dstReady);
endmodule

bind vdm_dma_front vdm_dma_front_props chk (.*);

//--- vdm_far_model.sv
/*
  Far side model: packet memory, data source and a slow data sink.
  Assumes a packet request is a one-cycle pulse from the engine.
*/
`timescale 1ns/1ps

module vdm_far_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pktReqValid,
  output logic pktRspValid,
  output logic [2:0] pktRspIndex,
  output logic [31:0] pktRspData,
  output logic srcValid,
  output logic [31:0] srcData,
  input wire logic srcReady,
  output logic dstReady
);
  // ****************************************************************
  // Packet memory and stream ends.
  // ****************************************************************
  logic busy_reg; // A packet is being returned.
  logic [2:0] idx_reg; // Next word index.
  logic [1:0] tick_reg; // Sink paces one word in four cycles.

  // Packet words: direction clear, 8 bytes, PCI and VME bases, last link.
  function automatic logic [31:0] pktWord(input logic [2:0] i);
    case (i)
      3'h1: return 32'h00000008;
      3'h2: return 32'h00003000;
      3'h4: return 32'h00004000;
      3'h6: return 32'h00000001;
      default: return 32'h0;
    endcase
  endfunction

  // Returns the eight words in order, then keeps the source and sink going.
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      busy_reg <= 1'b0;
      idx_reg <= 3'h0;
      tick_reg <= 2'h0;
      pktRspValid <= 1'b0;
      pktRspIndex <= 3'h0;
      pktRspData <= 32'h0;
      srcValid <= 1'b0;
      srcData <= 32'h0;
      dstReady <= 1'b0;
    end
    else
    begin
      if (pktReqValid)
        busy_reg <= 1'b1;
      else if (busy_reg && idx_reg == 3'h7)
        busy_reg <= 1'b0;
      pktRspValid <= busy_reg;
      pktRspIndex <= busy_reg ? idx_reg : ~pktRspIndex;
      pktRspData <= busy_reg ? pktWord(idx_reg) : ~pktRspData;
      if (busy_reg)
        idx_reg <= idx_reg + 3'h1;
      srcValid <= 1'b1;
      if (srcValid && srcReady)
        srcData <= srcData + 32'h1;
      tick_reg <= tick_reg + 2'h1;
      dstReady <= tick_reg == 2'h3;
    end
endmodule

//--- vdm_dma_front_bench.sv
/*
  Self-checking bench of the transfer-engine front end.
  Assumes the far side model answers packets and streams data.
*/
`timescale 1ns/1ps

module vdm_dma_front_bench;
  // ****************************************************************
  // Signals, clock and instances.
  // ****************************************************************
  logic ref_clk = 1'b0;
  logic rst, regWrite, regRead, pktReqValid, pktRspValid, srcValid, srcReady;
  logic dstValid, dstReady, engineActive, pciToVmeDirection, programDataSelect;
  logic supervisorSelect, irq, regRdValid;
  logic [11:0] regAddr;
  logic [31:0] regWrData, regRdData, pktReqAddr, pktRspData, srcData, dstData;
  logic [31:0] pciAddrOut, vmeAddrOut;
  logic [2:0] pktRspIndex, vmeAddressSpaceSelect;
  logic [11:0] ofs [7] = '{12'h200, 12'h204, 12'h208, 12'h210, 12'h218, 12'h220, 12'h300};
  int fail_count = 0;
  int n_compared = 0;

  always #2 ref_clk = ~ref_clk;

  vdm_dma_front dut (.ref_clk(ref_clk), .rst(rst), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
    .pktReqValid(pktReqValid), .pktReqAddr(pktReqAddr), .pktRspValid(pktRspValid),
    .pktRspIndex(pktRspIndex), .pktRspData(pktRspData), .xferError(1'b0),
    .srcValid(srcValid), .srcData(srcData), .srcReady(srcReady), .dstValid(dstValid),
    .dstData(dstData), .dstReady(dstReady), .engineActive(engineActive),
    .pciToVmeDirection(pciToVmeDirection), .vmeAddressSpaceSelect(vmeAddressSpaceSelect),
    .programDataSelect(programDataSelect), .supervisorSelect(supervisorSelect),
    .pciAddrOut(pciAddrOut), .vmeAddrOut(vmeAddrOut), .irq(irq));

  vdm_far_model far (.ref_clk(ref_clk), .rst(rst), .pktReqValid(pktReqValid),
    .pktRspValid(pktRspValid), .pktRspIndex(pktRspIndex), .pktRspData(pktRspData),
    .srcValid(srcValid), .srcData(srcData), .srcReady(srcReady), .dstReady(dstReady));

  // ****************************************************************
  // Access tasks.
  // ****************************************************************
  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Compares one value and counts the outcome.
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask

  // One-cycle register write pulse.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(negedge ref_clk);
    regAddr = a;
    regWrData = d;
    regWrite = 1'b1;
    @(negedge ref_clk);
    regWrite = 1'b0;
  endtask

  // Register read; the answer stands in the cycle after the request.
  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    @(negedge ref_clk);
    regAddr = a;
    regRead = 1'b1;
    @(negedge ref_clk);
    regRead = 1'b0;
    cmp({31'h0, regRdValid}, 32'h1);
    cmp(regRdData & m, e);
  endtask

  // Waits, bounded, for the engine to fall idle.
  task automatic wait_idle;
    int i;
    i = 0;
    @(negedge ref_clk);
    while (engineActive !== 1'b0 && i < 300)
    begin
      @(negedge ref_clk);
      i++;
    end
    if (i == 300)
    begin
      fail_count++;
      $display("MISMATCH %0t engine never idle", $time);
      give_verdict();
    end
  endtask

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial
  begin
    rst = 1'b1;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 12'h000;
    regWrData = 32'h0;
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    // Reset values and an unmapped offset all read zero.
    foreach (ofs[i]) rdc(ofs[i], 32'hffffffff, 32'h0);
    // Attribute fields reach their ports.
    wr(12'h200, 32'h80025000);
    cmp({28'h0, pciToVmeDirection, vmeAddressSpaceSelect}, 32'ha);
    cmp({30'h0, programDataSelect, supervisorSelect}, 32'h3);
    // Misaligned start is refused with a protocol error.
    wr(12'h208, 32'h1003);
    wr(12'h210, 32'h2005);
    wr(12'h204, 32'h8);
    wr(12'h220, 32'h80000001);
    wait_idle();
    rdc(12'h220, 32'h00000f00, 32'h100);
    cmp({31'h0, irq}, 32'h1);
    wr(12'h220, 32'h101);
    rdc(12'h220, 32'h00000f00, 32'h0);
    cmp({31'h0, irq}, 32'h0);
    // Zero count without chaining does nothing.
    wr(12'h204, 32'h0);
    wr(12'h220, 32'h80000001);
    wait_idle();
    rdc(12'h220, 32'h00008f00, 32'h0);
    // Direct run: locked while active, addresses kept, count zero.
    wr(12'h208, 32'h1000);
    wr(12'h210, 32'h2000);
    wr(12'h204, 32'h10);
    wr(12'h220, 32'h80000001);
    wr(12'h208, 32'h55555550);
    rdc(12'h204, 32'h00ffffff, 32'h10);
    rdc(12'h220, 32'h00008000, 32'h8000);
    wait_idle();
    rdc(12'h208, 32'hffffffff, 32'h1000);
    rdc(12'h210, 32'hffffffff, 32'h2000);
    rdc(12'h204, 32'h00ffffff, 32'h0);
    rdc(12'h220, 32'h00000800, 32'h800);
    // Chained run from one packet.
    wr(12'h220, 32'h00000f01);
    wr(12'h218, 32'h0000041f);
    rdc(12'h218, 32'hffffffff, 32'h400);
    wr(12'h220, 32'h88000001);
    wait_idle();
    rdc(12'h200, 32'hffffffff, 32'h0);
    cmp({31'h0, pciToVmeDirection}, 32'h0);
    rdc(12'h208, 32'hffffffff, 32'h3008);
    rdc(12'h210, 32'hffffffff, 32'h4008);
    rdc(12'h204, 32'h00ffffff, 32'h0);
    give_verdict();
  end
endmodule
